//--- core/irs_defs.svh
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH
// stream widths
`define IRS_DATA_W      64
`define IRS_KEEP_W      8
`define IRS_USER_W      32
`define IRS_ID_W        16
`define IRS_CNT_W       4
// sideband layout, header-encoded format
`define IRS_SRC_MSB     31
`define IRS_SRC_LSB     16
`define IRS_DST_MSB     15
`define IRS_DST_LSB     0
`define IRS_ID8_PAD     8'h00
// sideband layout, raw stream format
`define IRS_RAW_USER_W  8
`define IRS_CRF_BIT     1
// qualifier and reset values
`define IRS_KEEP_ALL    8'hFF
`define IRS_CNT_FULL    4'h8
`define IRS_CNT_ZERO    4'h0
`define IRS_USER_ZERO   32'h0000_0000
`define IRS_ID_ZERO     16'h0000
`define IRS_DATA_ZERO   64'h0000_0000_0000_0000
`endif

//--- core/irs_pkg.sv
package irs_pkg;
`include "irs_defs.svh"

  typedef logic [`IRS_DATA_W-1:0] irs_data_t;
  typedef logic [`IRS_KEEP_W-1:0] irs_keep_t;
  typedef logic [`IRS_USER_W-1:0] irs_user_t;
  typedef logic [`IRS_ID_W-1:0]   irs_id_t;
  typedef logic [`IRS_CNT_W-1:0]  irs_cnt_t;

  // port format, chosen by configuration
  typedef enum logic {IRS_FMT_HDR, IRS_FMT_RAW} irs_fmt_e;
  // position within a packet
  typedef enum logic {IRS_FIRST, IRS_BODY} irs_pkt_e;

  // last-beat qualifier: header leads at the top byte, so valid bytes are the upper n; zero or above eight gives all eight
  function automatic irs_keep_t irs_keep_mask(input irs_cnt_t n);
    irs_keep_t m;
    m = `IRS_KEEP_ALL;
    if (n != `IRS_CNT_ZERO && n < `IRS_CNT_FULL)
      m = irs_keep_t'(`IRS_KEEP_ALL << (`IRS_CNT_FULL - n));
    return m;
  endfunction

  // number of qualified bytes in a beat
  function automatic irs_cnt_t irs_keep_count(input irs_keep_t k);
    irs_cnt_t c;
    c = `IRS_CNT_ZERO;
    for (int i = 0; i < `IRS_KEEP_W; i++)
      if (k[i])
        c = c + 4'h1;
    return c;
  endfunction

  // header-encoded sideband: source high, destination low, 8-bit ids zero padded
  function automatic irs_user_t irs_user_hdr(input irs_id_t src, input irs_id_t dst,
                                             input logic id8);
    irs_id_t s;
    irs_id_t d;
    s = id8 ? {`IRS_ID8_PAD, src[7:0]} : src;
    d = id8 ? {`IRS_ID8_PAD, dst[7:0]} : dst;
    return {s, d};
  endfunction

  // raw stream sideband: only the flow flag, every reserved bit zero
  function automatic irs_user_t irs_user_raw(input logic crf);
    irs_user_t u;
    u = `IRS_USER_ZERO;
    u[`IRS_CRF_BIT] = crf;
    return u;
  endfunction
endpackage

//--- core/irs_stream_if.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
// request stream flows user to device, response stream device to user
interface irs_stream_if;
  logic                   ireq_tvalid;
  logic                   ireq_tready;
  logic [`IRS_DATA_W-1:0] ireq_tdata;
  logic [`IRS_KEEP_W-1:0] ireq_tkeep;
  logic                   ireq_tlast;
  logic [`IRS_USER_W-1:0] ireq_tuser;
  logic                   iresp_tvalid;
  logic                   iresp_tready;
  logic [`IRS_DATA_W-1:0] iresp_tdata;
  logic [`IRS_KEEP_W-1:0] iresp_tkeep;
  logic                   iresp_tlast;
  logic [`IRS_USER_W-1:0] iresp_tuser;

  modport dev (
    input  ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser, iresp_tready,
    output ireq_tready, iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser
  );
  modport usr (
    output ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser, iresp_tready,
    input  ireq_tready, iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser
  );
endinterface

//--- core/irs_beat_slice.sv
`timescale 1ns/1ps
// one-beat register stage; holds its word until taken
module irs_beat_slice #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  logic         full;
  logic         next_full;
  logic [W-1:0] word;
  logic [W-1:0] next_word;

  if (W < 1)
    $error("irs_beat_slice: W must be at least 1");

  // accept when empty or draining; no bypass, so the ready path stays one gate deep
  always_comb
  begin
    o_in_ready = !full || i_out_ready;
    next_full  = full;
    next_word  = word;
    if (full && i_out_ready)
      next_full = 1'b0;
    if (i_in_valid && o_in_ready)
    begin
      next_full = 1'b1;
      next_word = i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      full <= 1'b0;
      word <= '0;
    end
    else
    begin
      full <= next_full;
      word <= next_word;
    end
  end

  assign o_out_valid = full;
  assign o_out_data  = word;
endmodule

//--- core/irs_dev_end.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
// Overview of operation
// - first-beat sideband: source high, destination low
// - 8-bit ids padded with zero upper bytes
// - raw format: 8-bit sideband, bit 1 requests flow
// - flow bit zero when flow support disabled (requests only; raw responses still echo i_rsp_crf)
// - raw response bit 1 echoes packet flow flag
// - other raw sideband bits reserved, no meaning
// - sideband meaningful only on first packet beat
// - header format: response qualifiers all high
// - raw format: all high except last beat
// - qualifier bit n covers data byte n
// - beat taken only when ready and valid
// - last marker only on final packet beat
// - 64-bit response data: header then payload
// - raw request qualifiers high except final beat
// - valid raised whenever a beat is held
module irs_dev_end (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  irs_stream_if.dev         bus,
  input  wire logic         i_fmt_raw,
  input  wire logic         i_id8,
  output logic              o_req_valid,
  output irs_pkg::irs_data_t o_req_data,
  output logic              o_req_last,
  output irs_pkg::irs_cnt_t o_req_nbytes,
  output irs_pkg::irs_id_t  o_req_src_id,
  output irs_pkg::irs_id_t  o_req_dst_id,
  output logic              o_req_crf,
  output logic              o_req_keep_err,
  input  wire logic         i_req_ready,
  input  wire logic         i_rsp_valid,
  input  wire irs_pkg::irs_data_t i_rsp_data,
  input  wire logic         i_rsp_last,
  input  wire irs_pkg::irs_cnt_t i_rsp_nbytes,
  input  wire irs_pkg::irs_id_t  i_rsp_src_id,
  input  wire irs_pkg::irs_id_t  i_rsp_dst_id,
  input  wire logic         i_rsp_crf,
  output logic              o_rsp_ready
);
  import irs_pkg::*;

  localparam int REQ_W = `IRS_DATA_W + 1 + `IRS_CNT_W + 2 * `IRS_ID_W + 2;
  localparam int RSP_W = `IRS_DATA_W + `IRS_KEEP_W + 1 + `IRS_USER_W;

  irs_fmt_e         fmt;
  irs_fmt_e         next_fmt;
  irs_pkt_e         rq_state;
  irs_pkt_e         next_rq_state;
  irs_pkt_e         rs_state;
  irs_pkt_e         next_rs_state;
  irs_id_t          rq_src;
  irs_id_t          next_rq_src;
  irs_id_t          rq_dst;
  irs_id_t          next_rq_dst;
  logic             rq_crf;
  logic             next_rq_crf;
  logic             rq_take;
  logic             rs_take;
  irs_id_t          cur_src;
  irs_id_t          cur_dst;
  logic             cur_crf;
  logic             cur_err;
  logic [REQ_W-1:0] rq_word;
  logic [REQ_W-1:0] rq_out;
  irs_keep_t        rs_keep;
  irs_user_t        rs_user;
  logic [RSP_W-1:0] rs_word;
  logic [RSP_W-1:0] rs_out;

  // request handshake: a beat counts only with valid and ready together
  assign rq_take = bus.ireq_tvalid && bus.ireq_tready;
  assign rs_take = i_rsp_valid && o_rsp_ready;

  // decode the request sideband; later beats reuse what the first beat gave
  always_comb
  begin
    cur_src = rq_src;
    cur_dst = rq_dst;
    cur_crf = rq_crf;
    if (rq_state == IRS_FIRST)
    begin
      if (fmt == IRS_FMT_HDR)
      begin
        cur_src = bus.ireq_tuser[`IRS_SRC_MSB:`IRS_SRC_LSB];
        cur_dst = bus.ireq_tuser[`IRS_DST_MSB:`IRS_DST_LSB];
        if (i_id8)
        begin
          cur_src = {`IRS_ID8_PAD, cur_src[7:0]};
          cur_dst = {`IRS_ID8_PAD, cur_dst[7:0]};
        end
        cur_crf = 1'b0;
      end
      else
      begin
        // only the flow bit is looked at, the rest is reserved
        cur_src = `IRS_ID_ZERO;
        cur_dst = `IRS_ID_ZERO;
        cur_crf = bus.ireq_tuser[`IRS_CRF_BIT];
      end
    end
  end

  // qualifier check: partial beats are only legal at the end in raw format
  always_comb
  begin
    cur_err = 1'b0;
    if (bus.ireq_tkeep != `IRS_KEEP_ALL)
      cur_err = (fmt == IRS_FMT_HDR) || !bus.ireq_tlast;
  end

  // request packet position and held first-beat fields
  always_comb
  begin
    next_rq_state = rq_state;
    next_rq_src   = rq_src;
    next_rq_dst   = rq_dst;
    next_rq_crf   = rq_crf;
    if (rq_take)
    begin
      next_rq_src = cur_src;
      next_rq_dst = cur_dst;
      next_rq_crf = cur_crf;
      case (rq_state)
        IRS_FIRST: next_rq_state = bus.ireq_tlast ? IRS_FIRST : IRS_BODY;
        IRS_BODY:  next_rq_state = bus.ireq_tlast ? IRS_FIRST : IRS_BODY;
        default:   next_rq_state = IRS_FIRST;
      endcase
    end
  end

  // response packet position
  always_comb
  begin
    next_rs_state = rs_state;
    if (rs_take)
    begin
      case (rs_state)
        IRS_FIRST: next_rs_state = i_rsp_last ? IRS_FIRST : IRS_BODY;
        IRS_BODY:  next_rs_state = i_rsp_last ? IRS_FIRST : IRS_BODY;
        default:   next_rs_state = IRS_FIRST;
      endcase
    end
  end

  // format reloads only between packets on both streams; a change mid-packet waits
  always_comb
  begin
    next_fmt = fmt;
    if (rq_state == IRS_FIRST && rs_state == IRS_FIRST && !rq_take && !rs_take)
      next_fmt = i_fmt_raw ? IRS_FMT_RAW : IRS_FMT_HDR;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fmt      <= IRS_FMT_HDR;
      rq_state <= IRS_FIRST;
      rs_state <= IRS_FIRST;
      rq_src   <= `IRS_ID_ZERO;
      rq_dst   <= `IRS_ID_ZERO;
      rq_crf   <= 1'b0;
    end
    else
    begin
      fmt      <= next_fmt;
      rq_state <= next_rq_state;
      rs_state <= next_rs_state;
      rq_src   <= next_rq_src;
      rq_dst   <= next_rq_dst;
      rq_crf   <= next_rq_crf;
    end
  end

  // request beat toward the layer, registered
  assign rq_word = {bus.ireq_tdata, bus.ireq_tlast, irs_keep_count(bus.ireq_tkeep),
                    cur_src, cur_dst, cur_crf, cur_err};

  irs_beat_slice #(
    .W (REQ_W)
  ) u_req_slice (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (bus.ireq_tvalid),
    .i_in_data   (rq_word),
    .o_in_ready  (bus.ireq_tready),
    .o_out_valid (o_req_valid),
    .o_out_data  (rq_out),
    .i_out_ready (i_req_ready)
  );

  assign {o_req_data, o_req_last, o_req_nbytes, o_req_src_id, o_req_dst_id,
          o_req_crf, o_req_keep_err} = rq_out;

  // response qualifiers: full except the tail of a raw packet
  always_comb
  begin
    rs_keep = `IRS_KEEP_ALL;
    if (fmt == IRS_FMT_RAW && i_rsp_last)
      rs_keep = irs_keep_mask(i_rsp_nbytes);
  end

  // response sideband carries content on the first beat only, zero afterwards
  always_comb
  begin
    rs_user = `IRS_USER_ZERO;
    if (rs_state == IRS_FIRST)
    begin
      if (fmt == IRS_FMT_HDR)
        rs_user = irs_user_hdr(i_rsp_src_id, i_rsp_dst_id, i_id8);
      else
        rs_user = irs_user_raw(i_rsp_crf);
    end
  end

  assign rs_word = {i_rsp_data, rs_keep, i_rsp_last, rs_user};

  // the slice holds the beat stable and valid until the consumer takes it
  irs_beat_slice #(
    .W (RSP_W)
  ) u_rsp_slice (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_rsp_valid),
    .i_in_data   (rs_word),
    .o_in_ready  (o_rsp_ready),
    .o_out_valid (bus.iresp_tvalid),
    .o_out_data  (rs_out),
    .i_out_ready (bus.iresp_tready)
  );

  assign {bus.iresp_tdata, bus.iresp_tkeep, bus.iresp_tlast, bus.iresp_tuser} = rs_out;
endmodule

//--- core/irs_usr_end.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
// user-logic end: sends requests, receives responses
module irs_usr_end (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  irs_stream_if.usr         bus,
  input  wire logic         i_fmt_raw,
  input  wire logic         i_id8,
  input  wire logic         i_crf_en,
  input  wire logic         i_cmd_valid,
  input  wire irs_pkg::irs_data_t i_cmd_data,
  input  wire logic         i_cmd_last,
  input  wire irs_pkg::irs_cnt_t i_cmd_nbytes,
  input  wire irs_pkg::irs_id_t  i_cmd_src_id,
  input  wire irs_pkg::irs_id_t  i_cmd_dst_id,
  input  wire logic         i_cmd_crf,
  output logic              o_cmd_ready,
  output logic              o_resp_valid,
  output irs_pkg::irs_data_t o_resp_data,
  output logic              o_resp_last,
  output irs_pkg::irs_cnt_t o_resp_nbytes,
  output irs_pkg::irs_id_t  o_resp_src_id,
  output irs_pkg::irs_id_t  o_resp_dst_id,
  output logic              o_resp_crf,
  input  wire logic         i_resp_ready
);
  import irs_pkg::*;

  localparam int CMD_W = `IRS_DATA_W + `IRS_KEEP_W + 1 + `IRS_USER_W;
  localparam int RSP_W = `IRS_DATA_W + 1 + `IRS_CNT_W + 2 * `IRS_ID_W + 1;

  irs_fmt_e         fmt;
  irs_fmt_e         next_fmt;
  irs_pkt_e         tx_state;
  irs_pkt_e         next_tx_state;
  irs_pkt_e         rx_state;
  irs_pkt_e         next_rx_state;
  logic             tx_take;
  logic             rx_take;
  irs_keep_t        tx_keep;
  irs_user_t        tx_user;
  logic [CMD_W-1:0] tx_out;
  irs_id_t          rx_src;
  irs_id_t          rx_dst;
  logic             rx_crf;
  logic [RSP_W-1:0] rx_out;

  assign tx_take = i_cmd_valid && o_cmd_ready;
  assign rx_take = bus.iresp_tvalid && bus.iresp_tready;

  // request qualifiers and sideband; flow flag forced low when support is off
  always_comb
  begin
    tx_keep = `IRS_KEEP_ALL;
    if (fmt == IRS_FMT_RAW && i_cmd_last)
      tx_keep = irs_keep_mask(i_cmd_nbytes);
    tx_user = `IRS_USER_ZERO;
    if (tx_state == IRS_FIRST)
      tx_user = (fmt == IRS_FMT_HDR) ? irs_user_hdr(i_cmd_src_id, i_cmd_dst_id, i_id8)
                                     : irs_user_raw(i_cmd_crf && i_crf_en);
  end

  // response sideband read on the first beat only; reserved bits dropped
  always_comb
  begin
    rx_src = `IRS_ID_ZERO;
    rx_dst = `IRS_ID_ZERO;
    rx_crf = 1'b0;
    if (rx_state == IRS_FIRST && fmt == IRS_FMT_HDR)
    begin
      rx_src = bus.iresp_tuser[`IRS_SRC_MSB:`IRS_SRC_LSB];
      rx_dst = bus.iresp_tuser[`IRS_DST_MSB:`IRS_DST_LSB];
    end
    if (rx_state == IRS_FIRST && fmt == IRS_FMT_RAW)
      rx_crf = bus.iresp_tuser[`IRS_CRF_BIT];
  end

  // packet positions and format reload between packets
  always_comb
  begin
    next_tx_state = tx_state;
    next_rx_state = rx_state;
    next_fmt      = fmt;
    case (tx_state)
      IRS_FIRST: if (tx_take && !i_cmd_last) next_tx_state = IRS_BODY;
      IRS_BODY:  if (tx_take && i_cmd_last)  next_tx_state = IRS_FIRST;
      default:   next_tx_state = IRS_FIRST;
    endcase
    case (rx_state)
      IRS_FIRST: if (rx_take && !bus.iresp_tlast) next_rx_state = IRS_BODY;
      IRS_BODY:  if (rx_take && bus.iresp_tlast)  next_rx_state = IRS_FIRST;
      default:   next_rx_state = IRS_FIRST;
    endcase
    if (tx_state == IRS_FIRST && rx_state == IRS_FIRST && !tx_take && !rx_take)
      next_fmt = i_fmt_raw ? IRS_FMT_RAW : IRS_FMT_HDR;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fmt      <= IRS_FMT_HDR;
      tx_state <= IRS_FIRST;
      rx_state <= IRS_FIRST;
    end
    else
    begin
      fmt      <= next_fmt;
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
    end
  end

  irs_beat_slice #(
    .W (CMD_W)
  ) u_cmd_slice (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_cmd_valid),
    .i_in_data   ({i_cmd_data, tx_keep, i_cmd_last, tx_user}),
    .o_in_ready  (o_cmd_ready),
    .o_out_valid (bus.ireq_tvalid),
    .o_out_data  (tx_out),
    .i_out_ready (bus.ireq_tready)
  );

  assign {bus.ireq_tdata, bus.ireq_tkeep, bus.ireq_tlast, bus.ireq_tuser} = tx_out;

  irs_beat_slice #(
    .W (RSP_W)
  ) u_resp_slice (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (bus.iresp_tvalid),
    .i_in_data   ({bus.iresp_tdata, bus.iresp_tlast, irs_keep_count(bus.iresp_tkeep),
                   rx_src, rx_dst, rx_crf}),
    .o_in_ready  (bus.iresp_tready),
    .o_out_valid (o_resp_valid),
    .o_out_data  (rx_out),
    .i_out_ready (i_resp_ready)
  );

  assign {o_resp_data, o_resp_last, o_resp_nbytes, o_resp_src_id, o_resp_dst_id,
          o_resp_crf} = rx_out;
endmodule

//--- dv/irs_stream_props.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
// watches the joined interface; both ends are design code
module irs_stream_props (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_fmt_raw,
  input  wire logic                   i_crf_en,
  input  wire logic                   ireq_tvalid,
  input  wire logic                   ireq_tready,
  input  wire logic [`IRS_DATA_W-1:0] ireq_tdata,
  input  wire logic [`IRS_KEEP_W-1:0] ireq_tkeep,
  input  wire logic                   ireq_tlast,
  input  wire logic [`IRS_USER_W-1:0] ireq_tuser,
  input  wire logic                   iresp_tvalid,
  input  wire logic                   iresp_tready,
  input  wire logic [`IRS_DATA_W-1:0] iresp_tdata,
  input  wire logic [`IRS_KEEP_W-1:0] iresp_tkeep,
  input  wire logic                   iresp_tlast,
  input  wire logic [`IRS_USER_W-1:0] iresp_tuser
);
  logic req_first;
  logic resp_first;
  logic next_req_first;
  logic next_resp_first;

  // sideband only counts on a first beat, so packet boundaries are tracked here
  always_comb
  begin
    next_req_first = req_first;
    next_resp_first = resp_first;
    if (ireq_tvalid && ireq_tready)
      next_req_first = ireq_tlast;
    if (iresp_tvalid && iresp_tready)
      next_resp_first = iresp_tlast;
  end

  // boundary trackers start as first beat
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      req_first <= 1'b1;
      resp_first <= 1'b1;
    end
    else
    begin
      req_first <= next_req_first;
      resp_first <= next_resp_first;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_req_hold_stable: assert property (ireq_tvalid && !ireq_tready |=> ireq_tvalid &&
    $stable({ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser}))
    else $error("request beat changed while stalled");
  chk_resp_hold_stable: assert property (iresp_tvalid && !iresp_tready |=> iresp_tvalid &&
    $stable({iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser}))
    else $error("response beat changed while stalled");
  chk_hdr_resp_keep: assert property (!i_fmt_raw && iresp_tvalid |-> iresp_tkeep == 8'hFF)
    else $error("header response qualifier not all high");
  chk_raw_resp_keep: assert property (i_fmt_raw && iresp_tvalid && !iresp_tlast
    |-> iresp_tkeep == 8'hFF) else $error("raw response body qualifier not all high");
  chk_raw_req_keep: assert property (i_fmt_raw && ireq_tvalid && !ireq_tlast
    |-> ireq_tkeep == 8'hFF) else $error("raw request body qualifier not all high");
  chk_last_keep_upper: assert property (i_fmt_raw && iresp_tvalid && iresp_tlast |->
    iresp_tkeep != 8'h00 && (8'(~iresp_tkeep) & 8'(8'(~iresp_tkeep) + 8'h01)) == 8'h00)
    else $error("last response qualifier not upper bytes");
  chk_raw_resp_user: assert property (i_fmt_raw && iresp_tvalid && resp_first |->
    iresp_tuser[31:2] == 30'h0000_0000 && !iresp_tuser[0])
    else $error("raw response sideband reserved bit set");
  chk_raw_req_user: assert property (i_fmt_raw && ireq_tvalid && req_first |->
    ireq_tuser[31:2] == 30'h0000_0000 && !ireq_tuser[0]) else $error("raw request reserved bit");
  chk_crf_off_zero: assert property (i_fmt_raw && !i_crf_en && ireq_tvalid && req_first
    |-> !ireq_tuser[1]) else $error("flow flag set while flow support off");
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import irs_pkg::*;
  typedef struct {irs_data_t d; logic l; irs_cnt_t nb; irs_id_t s; irs_id_t t; logic c;
    irs_keep_t k; irs_user_t u; logic f;} irs_tbexp_s;
  logic i_core_clk, i_resetn, i_fmt_raw, i_id8, i_crf_en, i_req_ready, i_resp_ready;
  logic i_cmd_valid, i_cmd_last, i_cmd_crf, o_cmd_ready, i_rsp_valid, i_rsp_last, i_rsp_crf;
  logic o_rsp_ready, o_req_valid, o_req_last, o_req_crf, o_req_keep_err;
  logic o_resp_valid, o_resp_last, o_resp_crf;
  irs_data_t i_cmd_data, i_rsp_data, o_req_data, o_resp_data;
  irs_cnt_t  i_cmd_nbytes, i_rsp_nbytes, o_req_nbytes, o_resp_nbytes;
  irs_id_t   i_cmd_src_id, i_cmd_dst_id, i_rsp_src_id, i_rsp_dst_id;
  irs_id_t   o_req_src_id, o_req_dst_id, o_resp_src_id, o_resp_dst_id;
  irs_tbexp_s qrw[$], qro[$], qsw[$], qso[$];
  logic [31:0] seed = 32'h5688;
  int err_total = 0;
  int checks_done = 0;

  irs_stream_if bus ();
  irs_usr_end u_irs_usr_end (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .bus(bus),
    .i_fmt_raw(i_fmt_raw), .i_id8(i_id8), .i_crf_en(i_crf_en), .i_cmd_valid(i_cmd_valid),
    .i_cmd_data(i_cmd_data), .i_cmd_last(i_cmd_last), .i_cmd_nbytes(i_cmd_nbytes),
    .i_cmd_src_id(i_cmd_src_id), .i_cmd_dst_id(i_cmd_dst_id), .i_cmd_crf(i_cmd_crf),
    .o_cmd_ready(o_cmd_ready), .o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data),
    .o_resp_last(o_resp_last), .o_resp_nbytes(o_resp_nbytes), .o_resp_src_id(o_resp_src_id),
    .o_resp_dst_id(o_resp_dst_id), .o_resp_crf(o_resp_crf), .i_resp_ready(i_resp_ready));
  irs_dev_end u_irs_dev_end (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .bus(bus),
    .i_fmt_raw(i_fmt_raw), .i_id8(i_id8), .o_req_valid(o_req_valid), .o_req_data(o_req_data),
    .o_req_last(o_req_last), .o_req_nbytes(o_req_nbytes), .o_req_src_id(o_req_src_id),
    .o_req_dst_id(o_req_dst_id), .o_req_crf(o_req_crf), .o_req_keep_err(o_req_keep_err),
    .i_req_ready(i_req_ready), .i_rsp_valid(i_rsp_valid), .i_rsp_data(i_rsp_data),
    .i_rsp_last(i_rsp_last), .i_rsp_nbytes(i_rsp_nbytes), .i_rsp_src_id(i_rsp_src_id),
    .i_rsp_dst_id(i_rsp_dst_id), .i_rsp_crf(i_rsp_crf), .o_rsp_ready(o_rsp_ready));
  irs_stream_props u_irs_stream_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_fmt_raw(i_fmt_raw), .i_crf_en(i_crf_en), .ireq_tvalid(bus.ireq_tvalid),
    .ireq_tready(bus.ireq_tready), .ireq_tdata(bus.ireq_tdata), .ireq_tkeep(bus.ireq_tkeep),
    .ireq_tlast(bus.ireq_tlast), .ireq_tuser(bus.ireq_tuser), .iresp_tvalid(bus.iresp_tvalid),
    .iresp_tready(bus.iresp_tready), .iresp_tdata(bus.iresp_tdata),
    .iresp_tkeep(bus.iresp_tkeep), .iresp_tlast(bus.iresp_tlast), .iresp_tuser(bus.iresp_tuser));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmp(input logic [127:0] g, input logic [127:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one packet on the command side (dir 0) or the layer response side (dir 1)
  task automatic send_pkt(input bit dir, input int nb);
    irs_tbexp_s e;
    irs_id_t s, t, ps, pt;
    logic c;
    int n;
    bit ok;
    s = 16'(rnd());
    t = 16'(rnd());
    c = 1'(rnd());
    ps = i_id8 ? {8'h00, s[7:0]} : s;
    pt = i_id8 ? {8'h00, t[7:0]} : t;
    for (int b = 0; b < nb; b++)
    begin
      e.f = (b == 0);
      e.l = (b == nb - 1);
      n = e.l ? int'(rnd() % 8) + 1 : 8;
      e.k = (i_fmt_raw && e.l) ? 8'(8'hFF << (8 - n)) : 8'hFF;
      e.nb = (i_fmt_raw && e.l) ? 4'(n) : 4'h8;
      e.d = {rnd(), rnd()};
      for (int i = 0; i < 8; i++)
        if (!e.k[i])
          e.d[8*i+:8] = 8'h00;
      e.c = i_fmt_raw & c & (dir | i_crf_en);
      e.s = i_fmt_raw ? 16'h0000 : ps;
      e.t = i_fmt_raw ? 16'h0000 : pt;
      e.u = i_fmt_raw ? {30'h0000_0000, e.c, 1'b0} : {ps, pt};
      if (dir && b > 0) {e.s, e.t, e.c} = 33'h0;
      // later beats carry junk sideband the receiver ignores
      if (dir)
      begin
        i_rsp_valid <= 1'b1; i_rsp_data <= e.d; i_rsp_last <= e.l; i_rsp_nbytes <= 4'(n);
        i_rsp_src_id <= b ? 16'(rnd()) : s; i_rsp_dst_id <= b ? 16'(rnd()) : t;
        i_rsp_crf <= b ? 1'(rnd()) : c;
      end
      else
      begin
        i_cmd_valid <= 1'b1; i_cmd_data <= e.d; i_cmd_last <= e.l; i_cmd_nbytes <= 4'(n);
        i_cmd_src_id <= b ? 16'(rnd()) : s; i_cmd_dst_id <= b ? 16'(rnd()) : t;
        i_cmd_crf <= b ? 1'(rnd()) : c;
      end
      do
      begin
        @(negedge i_core_clk);
        ok = ((dir ? o_rsp_ready : o_cmd_ready) === 1'b1);
        @(posedge i_core_clk);
      end while (!ok);
      if (dir)
      begin
        qsw.push_back(e);
        qso.push_back(e);
      end
      else
      begin
        qrw.push_back(e);
        qro.push_back(e);
      end
    end
  endtask

  // packets back to back or with idle gaps
  task automatic stream(input bit dir, input int np);
    for (int p = 0; p < np; p++)
    begin
      send_pkt(dir, int'(rnd() % 4) + 1);
      if (p == np - 1 || rnd() % 2)
      begin
        if (dir)
          i_rsp_valid <= 1'b0;
        else
          i_cmd_valid <= 1'b0;
        @(posedge i_core_clk);
      end
    end
  endtask

  task automatic chk_wire(ref irs_tbexp_s q[$], input irs_data_t d, input irs_keep_t k,
                          input logic l, input irs_user_t u);
    irs_tbexp_s e;
    cmp(q.size() == 0, 1'b0, "unexpected wire beat");
    if (q.size() == 0)
      return;
    e = q.pop_front();
    cmp({d, k, l}, {e.d, e.k, e.l}, "wire beat");
    if (e.f)
      cmp(u, e.u, "wire sideband");
  endtask

  task automatic chk_out(ref irs_tbexp_s q[$], input irs_data_t d, input logic l,
                         input irs_cnt_t nb, input irs_id_t s, input irs_id_t t, input logic c);
    irs_tbexp_s e;
    cmp(q.size() == 0, 1'b0, "unexpected output beat");
    if (q.size() == 0)
      return;
    e = q.pop_front();
    cmp({d, l, nb}, {e.d, e.l, e.nb}, "output beat");
    cmp({s, t, c}, {e.s, e.t, e.c}, "output sideband");
  endtask

  // monitors see pre-edge values, so no race with the drivers
  always @(posedge i_core_clk)
  begin
    if (i_resetn && bus.ireq_tvalid && bus.ireq_tready)
      chk_wire(qrw, bus.ireq_tdata, bus.ireq_tkeep, bus.ireq_tlast, bus.ireq_tuser);
    if (i_resetn && bus.iresp_tvalid && bus.iresp_tready)
      chk_wire(qsw, bus.iresp_tdata, bus.iresp_tkeep, bus.iresp_tlast, bus.iresp_tuser);
    if (i_resetn && o_req_valid && i_req_ready)
    begin
      chk_out(qro, o_req_data, o_req_last, o_req_nbytes, o_req_src_id, o_req_dst_id,
              o_req_crf);
      cmp(o_req_keep_err, 1'b0, "qualifier error flag");
    end
    if (i_resetn && o_resp_valid && i_resp_ready)
      chk_out(qso, o_resp_data, o_resp_last, o_resp_nbytes, o_resp_src_id, o_resp_dst_id,
              o_resp_crf);
  end

  // consumers stall about a quarter of the time
  always @(posedge i_core_clk)
  begin
    i_req_ready <= (rnd() % 4) != 0;
    i_resp_ready <= (rnd() % 4) != 0;
  end

  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // a full run takes a few hundred cycles
  initial
  begin
    repeat (60000) @(posedge i_core_clk);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // four modes: header 16-bit, header 8-bit, raw with flow, raw without flow
  initial
  begin
    {i_resetn, i_fmt_raw, i_id8, i_crf_en, i_req_ready, i_resp_ready} = 6'h00;
    {i_cmd_valid, i_cmd_last, i_cmd_crf, i_rsp_valid, i_rsp_last, i_rsp_crf} = 6'h00;
    {i_cmd_data, i_rsp_data, i_cmd_nbytes, i_rsp_nbytes} = '0;
    {i_cmd_src_id, i_cmd_dst_id, i_rsp_src_id, i_rsp_dst_id} = '0;
    repeat (20) @(posedge i_core_clk);
    cmp({o_req_valid, o_resp_valid, bus.ireq_tvalid, bus.iresp_tvalid}, 0, "reset");
    i_resetn <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      i_fmt_raw <= (m >= 2);
      i_id8 <= (m == 1);
      i_crf_en <= (m != 3);
      repeat (5) @(posedge i_core_clk);
      fork
        stream(1'b0, 12);
        stream(1'b1, 12);
      join
      for (int w = 0; w < 200 && (qrw.size() + qro.size() + qsw.size() + qso.size()) > 0; w++)
        @(posedge i_core_clk);
      cmp(qrw.size() + qro.size() + qsw.size() + qso.size(), 0, "beats lost");
    end
    report_and_stop();
  end
endmodule
